/* cmlh_can_node.sv */
// Behavioural CAN node model that sends whatever object the handler offers
`timescale 1ns/1ps
module cmlh_can_node
   import cmlh_pkg::*;
(
   input  wire logic               clk,     // Module clock
   input  wire logic               rst,     // Synchronous reset
   input  wire logic               enable,  // Bench lets the node send
   input  wire logic               txReq,   // Offer from the handler
   input  wire cmlh_pkg::cmlh_ptr_t txObj,  // Offered object
   output logic                    txDone,  // Frame sent, one cycle
   output cmlh_pkg::cmlh_ptr_t     lastObj  // Object of the last frame
);
   int waitCnt; // Cycles left in the current frame
   // Random frame length, so offers are met both promptly and slowly
   always_ff @(posedge clk) begin
      txDone <= 1'b0;
      if (rst) begin
         waitCnt <= 0;
         lastObj <= '0;
      end else if (txDone || !(enable && txReq)) begin
         // Reload also keeps completions at least three cycles apart
         waitCnt <= 1 + $urandom_range(3);
      end else if (waitCnt > 0) begin
         waitCnt <= waitCnt - 1;
      end else begin
         // Latch late: the offer may still change before frame start
         txDone  <= 1'b1;
         lastObj <= txObj;
      end
   end
endmodule

/* cmlh_cfg.svh */
// Offsets, field positions, reset values and sizes of the object list handler
`ifndef CMLH_CFG_SVH
`define CMLH_CFG_SVH
// Object count and pointer width
`define CMLH_NUM_OBJ      8
`define CMLH_PTR_W        3
`define CMLH_ID_W         11
// Address map: objects in the low span, global status above it
`define CMLH_OBJ_SPAN     12'h080
`define CMLH_OFF_STATUS   12'h100
`define CMLH_OFF_CTRL     2'h0
`define CMLH_OFF_FUNC     2'h1
`define CMLH_OFF_FPTR     2'h2
`define CMLH_OFF_ARB      2'h3
// Control word fields
`define CMLH_CTRL_VALID   0
`define CMLH_CTRL_TRANSMIT_REQUEST    1
`define CMLH_CTRL_TXENA   2
`define CMLH_CTRL_TXENB   3
`define CMLH_CTRL_RECEIVE_ENABLE    4
`define CMLH_CTRL_DIR     5
`define CMLH_CTRL_RECEIVE_UPDATING   6
// Function word fields
`define CMLH_FUNC_MODE    1:0
`define CMLH_FUNC_SDT     2
`define CMLH_FUNC_OVERFLOW_IRQ_ENABLE    3
`define CMLH_FUNC_FREM    4
`define CMLH_FUNC_IRQL    6:5
`define CMLH_FUNC_NEXT    10:8
// FIFO pointer word fields
`define CMLH_FPTR_CUR     2:0
`define CMLH_FPTR_BOT     10:8
`define CMLH_FPTR_TOP     18:16
`define CMLH_FPTR_SEL     26:24
// Arbitration word fields
`define CMLH_ARB_ID       10:0
`define CMLH_ARB_PRI      13:12
// Status word fields
`define CMLH_STAT_LERR    0
`define CMLH_STAT_TXREQ   1
`define CMLH_STAT_TXOBJ   6:4
// Reset values
`define CMLH_RST_CUR      3'h0
`define CMLH_RST_PRI      2'h3
`endif

/* cmlh_list_handler.sv */
// Message object list handler: filtering, storage, FIFO pointers and APB registers
`timescale 1ns/1ps
module cmlh_list_handler
   import cmlh_pkg::*;
(
   input  wire logic             clk,        // Module clock, 20 MHz
   input  wire logic             rst,        // Synchronous reset, active high
   input  wire logic             psel,       // APB select
   input  wire logic             penable,    // APB access phase
   input  wire logic             pwrite,     // APB direction, high for write
   input  wire logic [11:0]      paddr,      // APB byte address
   input  wire logic [31:0]      pwdata,     // APB write data
   output logic      [31:0]      prdata,     // APB read data
   output logic                  pready,     // APB ready
   output logic                  pslverr,    // APB error on unmapped address
   input  wire logic             rxStb,      // Frame received, one cycle
   input  wire cmlh_pkg::cmlh_id_t rxId,     // Received identifier
   input  wire logic             rxRemote,   // Received frame is a remote frame
   input  wire logic             nodeStart,  // Another node starts a transfer
   input  wire logic             txDone,     // Offered object sent successfully
   output logic                  txReq,      // An object is offered for sending
   output cmlh_pkg::cmlh_ptr_t   txObj,      // Object offered for sending
   output logic                  rxIrq,      // Receive interrupt pulse
   output logic      [1:0]       rxIrqLine,  // Line of the receive interrupt
   output logic                  ovfIrq      // Transmit FIFO overflow pulse
);
   import cmlh_pkg::*;

   cmlh_state_t s;       // Registered state
   cmlh_state_t next_s;  // Next state

   logic [`CMLH_NUM_OBJ-1:0] txElig;    // Object may enter a transmit round
   logic [`CMLH_NUM_OBJ-1:0] rxHit;     // Object accepts the received frame
   logic [`CMLH_NUM_OBJ-1:0] curZero;   // Current pointer is object zero
   logic                     wrCtrl;    // Control word written this cycle
   logic                     wrPtr;     // Pointer word written this cycle

   // Helper decodes for the checks below
   assign wrCtrl = psel && penable && pwrite && s.pready && paddr < `CMLH_OBJ_SPAN &&
                   paddr[3:2] == `CMLH_OFF_CTRL;
   assign wrPtr  = psel && penable && pwrite && s.pready && paddr < `CMLH_OBJ_SPAN &&
                   paddr[3:2] == `CMLH_OFF_FPTR;

   // Priority key: class, then identifier, then data before remote
   function automatic logic [13:0] objKey(input cmlh_obj_t o);
      objKey = {o.priority_class, o.id, ~o.dir};
   endfunction

   // FIFO pointer step with wrap from top back to bottom
   function automatic cmlh_ptr_t nextPtr(input cmlh_obj_t o);
      nextPtr = (o.cur == o.top) ? o.bottom_pointer : o.cur + 3'h1;
   endfunction

   // Per-object eligibility, evaluated on the live state every cycle
   genvar g;
   generate
      for (g = 0; g < `CMLH_NUM_OBJ; g++) begin : gObj
         // Slaves are offered through their base, never on their own
         assign txElig[g] = s.obj[g].valid && s.obj[g].transmit_request && s.obj[g].txEnA && s.obj[g].txEnB &&
                            s.obj[g].mode != MODE_SLAVE;
         // Receive match: data frames hit receivers, remote frames hit data senders
         assign rxHit[g] = s.obj[g].valid && s.obj[g].receive_enable && s.obj[g].id == rxId &&
                           s.obj[g].dir == rxRemote && s.obj[g].mode != MODE_SLAVE &&
                           s.obj[g].mode != MODE_TXBASE;
         assign curZero[g] = s.obj[g].cur == `CMLH_RST_CUR;
      end
   endgenerate

   // All next-state logic
   always_comb begin
      logic      wrEn;
      logic      isObj;
      logic      isStat;
      cmlh_ptr_t ai;
      logic [1:0] ar;
      logic [31:0] rd;
      logic      found;
      cmlh_ptr_t w;
      logic      mFound;
      cmlh_ptr_t m;
      cmlh_ptr_t t;
      cmlh_ptr_t b;
      cmlh_ptr_t k;
      cmlh_ptr_t nc;
      wrEn   = 1'b0;
      isObj  = 1'b0;
      isStat = 1'b0;
      ai     = '0;
      ar     = '0;
      rd     = 32'h00000000;
      found  = 1'b0;
      w      = '0;
      mFound = 1'b0;
      m      = '0;
      t      = '0;
      b      = '0;
      k      = '0;
      nc     = '0;
      next_s = s;
      // Pulses last one cycle
      next_s.rxIrq  = 1'b0;
      next_s.ovfIrq = 1'b0;

      // APB decode; the address is stable through setup and access
      isObj  = paddr < `CMLH_OBJ_SPAN;
      isStat = paddr == `CMLH_OFF_STATUS;
      ai     = paddr[6:4];
      ar     = paddr[3:2];
      // Ready is raised in the setup cycle so the access completes at once
      next_s.pready = psel && !penable;
      wrEn = psel && penable && pwrite && s.pready;

      // Read data and error captured in the setup cycle
      if (isObj && ar == `CMLH_OFF_CTRL) begin
         rd[`CMLH_CTRL_VALID] = s.obj[ai].valid;
         rd[`CMLH_CTRL_TRANSMIT_REQUEST]  = s.obj[ai].transmit_request;
         rd[`CMLH_CTRL_TXENA] = s.obj[ai].txEnA;
         rd[`CMLH_CTRL_TXENB] = s.obj[ai].txEnB;
         rd[`CMLH_CTRL_RECEIVE_ENABLE]  = s.obj[ai].receive_enable;
         rd[`CMLH_CTRL_DIR]   = s.obj[ai].dir;
         rd[`CMLH_CTRL_RECEIVE_UPDATING] = s.obj[ai].receive_updating;
      end else if (isObj && ar == `CMLH_OFF_FUNC) begin
         rd[`CMLH_FUNC_MODE] = s.obj[ai].mode;
         rd[`CMLH_FUNC_SDT]  = s.obj[ai].single_transfer;
         rd[`CMLH_FUNC_OVERFLOW_IRQ_ENABLE] = s.obj[ai].overflow_irq_enable;
         rd[`CMLH_FUNC_FREM] = s.obj[ai].fRemEn;
         rd[`CMLH_FUNC_IRQL] = s.obj[ai].irqLine;
         rd[`CMLH_FUNC_NEXT] = s.obj[ai].next;
      end else if (isObj && ar == `CMLH_OFF_FPTR) begin
         rd[`CMLH_FPTR_CUR] = s.obj[ai].cur;
         rd[`CMLH_FPTR_BOT] = s.obj[ai].bottom_pointer;
         rd[`CMLH_FPTR_TOP] = s.obj[ai].top;
         rd[`CMLH_FPTR_SEL] = s.obj[ai].sel;
      end else if (isObj) begin
         rd[`CMLH_ARB_ID]  = s.obj[ai].id;
         rd[`CMLH_ARB_PRI] = s.obj[ai].priority_class;
      end else if (isStat) begin
         rd[`CMLH_STAT_LERR]  = s.listErr;
         rd[`CMLH_STAT_TXREQ] = s.txReq;
         rd[`CMLH_STAT_TXOBJ] = s.txObj;
      end
      if (psel && !penable) begin
         next_s.prdata  = rd;
         next_s.pslverr = !(isObj || isStat);
      end

      // Transmit round: whole object set scanned in one cycle, no list walk
      if (s.roundReq || nodeStart) begin
         for (int i = 0; i < `CMLH_NUM_OBJ; i++) begin
            if (txElig[i] && (!found || objKey(s.obj[i]) < objKey(s.obj[w]))) begin
               found = 1'b1;
               w     = cmlh_ptr_t'(i);
            end
         end
         next_s.roundReq = 1'b0;
         next_s.txReq    = found;
         next_s.txFifo   = found && s.obj[w].mode == MODE_TXBASE;
         next_s.txBase   = w;
         // A FIFO base offers the element its current pointer selects
         next_s.txObj    = (found && s.obj[w].mode == MODE_TXBASE) ? s.obj[w].cur : w;
      end

      // Software writes; each touches only the addressed object
      if (wrEn && isObj) begin
         if (ar == `CMLH_OFF_CTRL) begin
            next_s.obj[ai].valid = pwdata[`CMLH_CTRL_VALID];
            next_s.obj[ai].transmit_request  = pwdata[`CMLH_CTRL_TRANSMIT_REQUEST];
            next_s.obj[ai].txEnA = pwdata[`CMLH_CTRL_TXENA];
            next_s.obj[ai].txEnB = pwdata[`CMLH_CTRL_TXENB];
            next_s.obj[ai].receive_enable  = pwdata[`CMLH_CTRL_RECEIVE_ENABLE];
            next_s.obj[ai].dir   = pwdata[`CMLH_CTRL_DIR];
            // Every control write reruns filtering, clears included
            next_s.roundReq = 1'b1;
         end else if (ar == `CMLH_OFF_FUNC) begin
            next_s.obj[ai].mode    = cmlh_mode_t'(pwdata[`CMLH_FUNC_MODE]);
            next_s.obj[ai].single_transfer     = pwdata[`CMLH_FUNC_SDT];
            next_s.obj[ai].overflow_irq_enable    = pwdata[`CMLH_FUNC_OVERFLOW_IRQ_ENABLE];
            next_s.obj[ai].fRemEn  = pwdata[`CMLH_FUNC_FREM];
            next_s.obj[ai].irqLine = pwdata[`CMLH_FUNC_IRQL];
            next_s.obj[ai].next    = pwdata[`CMLH_FUNC_NEXT];
            // Relinking also reruns, so a moved successor is never missed
            next_s.roundReq = 1'b1;
         end else if (ar == `CMLH_OFF_FPTR) begin
            next_s.obj[ai].cur = pwdata[`CMLH_FPTR_CUR];
            next_s.obj[ai].bottom_pointer = pwdata[`CMLH_FPTR_BOT];
            next_s.obj[ai].top = pwdata[`CMLH_FPTR_TOP];
            next_s.obj[ai].sel = pwdata[`CMLH_FPTR_SEL];
         end else begin
            next_s.obj[ai].id  = pwdata[`CMLH_ARB_ID];
            next_s.obj[ai].priority_class = pwdata[`CMLH_ARB_PRI];
            next_s.roundReq = 1'b1;
         end
      end
      // Status: write one to clear the list error
      if (wrEn && isStat && pwdata[`CMLH_STAT_LERR]) begin
         next_s.listErr = 1'b0;
      end
      // Only an inverted FIFO segment counts as an inconsistency;
      // emptying a list is legal and leaves the flag alone
      if (wrEn && isObj && ar == `CMLH_OFF_FPTR && s.obj[ai].mode != MODE_STD &&
          pwdata[`CMLH_FPTR_BOT] > pwdata[`CMLH_FPTR_TOP]) begin
         next_s.listErr = 1'b1;
      end

      // Successful transmission of the offered object
      if (txDone && s.txReq) begin
         k = s.txObj;
         b = s.txBase;
         next_s.txReq    = 1'b0;
         next_s.roundReq = 1'b1;
         if (!s.txFifo) begin
            // Standard or receive base: no receive interrupt from a send
            next_s.obj[k].transmit_request = 1'b0;
            if (s.obj[k].single_transfer) begin
               next_s.obj[k].valid = 1'b0;
            end
         end else begin
            // Slave drops its own request; the base keeps the FIFO armed
            if (k != b) begin
               next_s.obj[k].transmit_request = 1'b0;
               if (s.obj[k].single_transfer) begin
                  next_s.obj[k].valid = 1'b0;
               end
            end
            nc = nextPtr(s.obj[b]);
            next_s.obj[b].cur = nc;
            if (s.obj[b].single_transfer && nc == s.obj[b].sel) begin
               next_s.obj[b].valid = 1'b0;
            end
            // Holds for the base's own element too
            if (s.obj[b].overflow_irq_enable && nc == s.obj[b].sel) begin
               next_s.ovfIrq = 1'b1;
            end
         end
      end

      // Storage, second cycle: write, drop the flag, status and interrupt
      if (s.store == STORE_WRITE) begin
         t = s.stTgt;
         b = s.stBase;
         next_s.store       = STORE_IDLE;
         next_s.obj[t].id   = s.stId;
         next_s.obj[t].receive_updating = 1'b0;
         next_s.rxIrq       = 1'b1;
         next_s.rxIrqLine   = s.obj[t].irqLine;
         // A base that stored into itself is judged by its pointers only
         if (s.obj[t].single_transfer && !(s.stFifo && t == b)) begin
            next_s.obj[t].valid = 1'b0;
         end
         if (s.stFifo) begin
            nc = nextPtr(s.obj[b]);
            next_s.obj[b].cur = nc;
            if (s.obj[b].single_transfer && nc == s.obj[b].sel) begin
               next_s.obj[b].valid = 1'b0;
            end
         end
      end

      // Receive filtering over the whole set, lowest class then index
      if (rxStb && s.store == STORE_IDLE) begin
         for (int i = 0; i < `CMLH_NUM_OBJ; i++) begin
            if (rxHit[i] && (!mFound || s.obj[i].priority_class < s.obj[m].priority_class)) begin
               mFound = 1'b1;
               m      = cmlh_ptr_t'(i);
            end
         end
         if (mFound && rxRemote) begin
            next_s.obj[m].transmit_request = 1'b1;
            if (s.obj[m].fRemEn && s.obj[m].cur == m) begin
               // Immediate answer suppressed; normal round picks it up
               next_s.roundReq = 1'b1;
            end else if (!s.txReq || objKey(s.obj[m]) < objKey(s.obj[s.txObj])) begin
               // Beats the current winner by priority key: class, then identifier, then data first
               next_s.txReq  = 1'b1;
               next_s.txObj  = m;
               next_s.txBase = m;
               next_s.txFifo = 1'b0;
            end else begin
               next_s.roundReq = 1'b1;
            end
         end else if (mFound) begin
            // Only the real target is flagged: for a receive base, the object its current pointer selects
            t = (s.obj[m].mode == MODE_RXBASE) ? s.obj[m].cur : m;
            next_s.obj[t].receive_updating = 1'b1;
            next_s.store  = STORE_WRITE;
            next_s.stTgt  = t;
            next_s.stBase = m;
            next_s.stFifo = s.obj[m].mode == MODE_RXBASE;
            next_s.stId   = rxId;
         end
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= resetImage();
      end else begin
         s <= next_s;
      end
   end

   // Reset image: every object cleared except class 3, current pointers at object zero
   function automatic cmlh_state_t resetImage();
      cmlh_state_t r;
      r = '0;
      for (int i = 0; i < `CMLH_NUM_OBJ; i++) begin
         r.obj[i].cur = `CMLH_RST_CUR;
         r.obj[i].priority_class = `CMLH_RST_PRI;
      end
      r.store = STORE_IDLE;
      return r;
   endfunction

   // Outputs straight from state flops
   assign prdata    = s.prdata;
   assign pready    = s.pready;
   assign pslverr   = s.pslverr;
   assign txReq     = s.txReq;
   assign txObj     = s.txObj;
   assign rxIrq     = s.rxIrq;
   assign rxIrqLine = s.rxIrqLine;
   assign ovfIrq    = s.ovfIrq;

   // Pointers at object zero right after reset
   cur_reset_a: assert property (@(posedge clk) $fell(rst) |-> &curZero)
      else $error("current pointer not zero after reset");

   // Flag stands while the write cycle runs
   receive_updating_set_a: assert property (@(posedge clk) disable iff (rst)
      (s.store == STORE_WRITE) |-> s.obj[s.stTgt].receive_updating)
      else $error("receive-updating flag missing during store");

   // Flag gone one cycle later
   receive_updating_clear_a: assert property (@(posedge clk) disable iff (rst)
      (s.store == STORE_WRITE) |=> !s.obj[$past(s.stTgt)].receive_updating)
      else $error("receive-updating flag not cleared after store");

   // Standard single transfer invalidates the sent object
   sdt_clear_a: assert property (@(posedge clk) disable iff (rst)
      (txDone && s.txReq && !s.txFifo && s.obj[s.txObj].single_transfer && !wrCtrl) |=> !s.obj[$past(s.txObj)].valid)
      else $error("single transfer left object valid");

   // Overflow pulse follows the pointer reaching select
   ovf_irq_a: assert property (@(posedge clk) disable iff (rst)
      (txDone && s.txReq && s.txFifo && s.obj[s.txBase].overflow_irq_enable &&
       nextPtr(s.obj[s.txBase]) == s.obj[s.txBase].sel) |=> ovfIrq)
      else $error("transmit FIFO overflow interrupt missing");

   // Overflow only ever follows a completed send
   ovf_cause_a: assert property (@(posedge clk) disable iff (rst)
      ovfIrq |-> $past(txDone))
      else $error("overflow interrupt without transmission");

   // Receive interrupts come only from storage, never from sending
   rx_irq_a: assert property (@(posedge clk) disable iff (rst)
      rxIrq |-> $past(s.store == STORE_WRITE))
      else $error("receive interrupt without storage");

   // Control writes rerun filtering; a send or frame may request another
   round_trig_a: assert property (@(posedge clk) disable iff (rst)
      wrCtrl |=> s.roundReq ##1 (!s.roundReq || $past(txDone && s.txReq) || $past(rxStb)))
      else $error("control write did not start a round");

   // Base pointer wraps from top to bottom
   ptr_wrap_a: assert property (@(posedge clk) disable iff (rst)
      (txDone && s.txReq && s.txFifo && s.obj[s.txBase].cur == s.obj[s.txBase].top && !wrPtr)
      |=> s.obj[$past(s.txBase)].cur == $past(s.obj[s.txBase].bottom_pointer))
      else $error("FIFO pointer did not wrap");
endmodule

/* cmlh_pkg.sv */
// Types shared by the object list handler
package cmlh_pkg;
`include "cmlh_cfg.svh"
   typedef logic [`CMLH_PTR_W-1:0] cmlh_ptr_t;
   typedef logic [`CMLH_ID_W-1:0]  cmlh_id_t;
   // Object roles
   typedef enum logic [1:0] {MODE_STD, MODE_RXBASE, MODE_TXBASE, MODE_SLAVE} cmlh_mode_t;
   // Storage sequencer states
   typedef enum logic {STORE_IDLE, STORE_WRITE} cmlh_store_t;
   // One message object
   typedef struct packed {
      logic       valid;
      logic       transmit_request;
      logic       txEnA;
      logic       txEnB;
      logic       receive_enable;
      logic       dir;
      logic       receive_updating;
      cmlh_mode_t mode;
      logic       single_transfer;
      logic       overflow_irq_enable;
      logic       fRemEn;
      logic [1:0] irqLine;
      cmlh_ptr_t  next;
      cmlh_ptr_t  cur;
      cmlh_ptr_t  bottom_pointer;
      cmlh_ptr_t  top;
      cmlh_ptr_t  sel;
      cmlh_id_t   id;
      logic [1:0] priority_class;
   } cmlh_obj_t;
   // Whole module state
   typedef struct packed {
      cmlh_obj_t [`CMLH_NUM_OBJ-1:0] obj;
      logic        listErr;
      logic        roundReq;
      logic        txReq;
      cmlh_ptr_t   txObj;
      cmlh_ptr_t   txBase;
      logic        txFifo;
      cmlh_store_t store;
      cmlh_ptr_t   stTgt;
      cmlh_ptr_t   stBase;
      logic        stFifo;
      cmlh_id_t    stId;
      logic        rxIrq;
      logic [1:0]  rxIrqLine;
      logic        ovfIrq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } cmlh_state_t;
endpackage

/* test_can_message_object_list_handler.sv */
// Self-checking bench for the object list handler
`timescale 1ns/1ps
module test_can_message_object_list_handler;
   import cmlh_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, er; // Clock, reset, bus
   logic [11:0] paddr;                                               // Bus address
   logic [31:0] pwdata, prdata, rd;                                  // Bus data, last read
   logic        rxStb, rxRemote, nodeStart, nodeEn, txDone, txReq;   // Node side
   logic        rxIrq, ovfIrq, hit, m;                               // Interrupts, scratch
   logic [1:0]  rxIrqLine, line;                                     // Interrupt line
   cmlh_id_t    rxId, id;                                            // Identifiers
   cmlh_ptr_t   txObj, lastObj, o;                                   // Object numbers
   int          fails, totalChecks, cyc;                             // Counters

   cmlh_list_handler dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxStb(rxStb), .rxId(rxId), .rxRemote(rxRemote), .nodeStart(nodeStart), .txDone(txDone),
      .txReq(txReq), .txObj(txObj), .rxIrq(rxIrq), .rxIrqLine(rxIrqLine), .ovfIrq(ovfIrq));
   cmlh_can_node node_u (.clk(clk), .rst(rst), .enable(nodeEn), .txReq(txReq), .txObj(txObj),
      .txDone(txDone), .lastObj(lastObj));

   // Byte address of word r of object n
   function automatic logic [11:0] oa(input int n, input int r);
      return 12'(n * 16 + r * 4);
   endfunction

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready, a spare edge keeps drives apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask

   // Let the node send one frame and report its object
   task automatic sendOne(output cmlh_ptr_t s);
      int n;
      n = 0;
      nodeEn <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (txDone !== 1'b1);
      s = lastObj;
      nodeEn <= 1'b0;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      rst = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      rxStb = 0; rxRemote = 0; nodeStart = 0; nodeEn = 0; rxId = '0;
      fails = 0; totalChecks = 0; cyc = 0;
      void'($urandom(32'hB0878619));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values of every object
      for (int n = 0; n < 8; n++) begin
         apb(1'b0, oa(n, 2), '0);
         chk("fptr", rd, 32'h0);
         apb(1'b0, oa(n, 3), '0);
         chk("arb", rd, 32'h0000_3000);
      end
      apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
      chk("slverr", 32'(er), 32'h1);
      apb(1'b0, 12'h0F0, '0);
      chk("unmapped", rd, 32'h0);
      $display("test reset and map done");
      // Class two, equal identifiers: data frame before remote frame
      id = cmlh_id_t'($urandom);
      apb(1'b1, oa(0, 1), 32'h4);
      apb(1'b1, oa(0, 0), 32'h1);
      apb(1'b1, oa(3, 3), 32'h2000 | 32'(id));
      apb(1'b1, oa(5, 3), 32'h2000 | 32'(id));
      apb(1'b1, oa(3, 0), 32'h0F);
      apb(1'b1, oa(5, 0), 32'h2F);
      repeat (3) @(posedge clk);
      chk("offer", 32'(txObj), 32'h5);
      sendOne(o);
      chk("first sent", 32'(o), 32'h5);
      sendOne(o);
      chk("second sent", 32'(o), 32'h3);
      apb(1'b0, oa(5, 0), '0);
      chk("ctrl5", rd, 32'h2D);
      // Single transfer clears only its own valid bit
      apb(1'b1, oa(5, 1), 32'h4);
      apb(1'b1, oa(5, 0), 32'h2F);
      sendOne(o);
      chk("sdt sent", 32'(o), 32'h5);
      apb(1'b0, oa(5, 0), '0);
      chk("ctrl5 sdt", rd, 32'h2C);
      apb(1'b0, oa(0, 0), '0);
      chk("ctrl0", rd, 32'h1);
      apb(1'b0, oa(3, 0), '0);
      chk("ctrl3", rd, 32'h0D);
      $display("test transmit done");
      // Reception, matching and missing identifiers at random
      line = 2'($urandom);
      apb(1'b1, oa(1, 3), 32'h1000 | 32'(id));
      apb(1'b1, oa(1, 1), 32'(line) << 5);
      apb(1'b1, oa(1, 0), 32'h11);
      for (int k = 0; k < 6; k++) begin
         m = 1'($urandom);
         rxId <= m ? id : id ^ 11'h001;
         rxStb <= 1'b1;
         @(posedge clk);
         rxStb <= 1'b0;
         hit = 1'b0;
         repeat (4) begin
            @(posedge clk);
            if (rxIrq === 1'b1) begin
               hit = 1'b1;
               chk("irq line", 32'(rxIrqLine), 32'(line));
            end
         end
         chk("rx irq", 32'(hit), 32'(m));
      end
      apb(1'b0, oa(1, 0), '0);
      chk("ctrl1", rd, 32'h11);
      apb(1'b0, 12'h100, '0);
      chk("list error", rd & 32'h1, 32'h0);
      $display("test receive done");
      // Transmit FIFO: base 6 at bottom, slave 7, select back at bottom
      apb(1'b1, oa(6, 1), 32'h0A);
      apb(1'b1, oa(7, 1), 32'h03);
      apb(1'b1, oa(6, 2), 32'h0607_0606);
      apb(1'b1, oa(7, 0), 32'h2F);
      apb(1'b1, oa(6, 0), 32'h2F);
      sendOne(o);
      chk("fifo base sent", 32'(o), 32'h6);
      @(posedge clk);
      chk("no ovf", 32'(ovfIrq), 32'h0);
      sendOne(o);
      chk("fifo slave sent", 32'(o), 32'h7);
      @(posedge clk);
      chk("ovf", 32'(ovfIrq), 32'h1);
      apb(1'b0, oa(6, 2), '0);
      chk("fifo wrap", rd, 32'h0607_0606);
      $display("test fifo done");
      finish_test();
   end
endmodule
